// [logic/serial_node_switch_config.sv]
`timescale 1ns/1ps
// Function
// - Switches one to six form node address, switch one least significant.
// - A switch that is on reads as one, off as zero.
// - Switches seven and eight form bit-rate code, seven is bit zero.
// - Switch values affect only the multidrop port, never the point-to-point port.
// - A zero field takes the stored value instead, each field on its own.
// - Rate code one is 9.6k, two 38.4k, three 115.2k bits per second.
module serial_node_switch_config #(
   parameter int unsigned SETTLE = swcfg_pkg::SETTLE_CYC
) (
   // Clock and reset
   input  wire logic                          mclk_i,
   input  wire logic                          rst_i,
   // Switch bank, one bit per switch, switch one at bit 0
   input  wire logic [swcfg_pkg::SW_COUNT-1:0] sw_i,
   // Interface selection pin, low selects multidrop
   input  wire logic                          if_sel_n_i,
   // APB slave
   input  wire logic                          psel_i,
   input  wire logic                          penable_i,
   input  wire logic                          pwrite_i,
   input  wire logic [11:0]                   paddr_i,
   input  wire logic [31:0]                   pwdata_i,
   output logic                               pready_o,
   output logic      [31:0]                   prdata_o,
   output logic                               pslverr_o,
   // Multidrop port configuration
   output logic                               md_enable_o,
   output logic      [swcfg_pkg::ADDR_W-1:0]  md_addr_o,
   output logic      [swcfg_pkg::RATE_W-1:0]  md_rate_o,
   output logic      [swcfg_pkg::BPS_W-1:0]   md_bps_o,
   output logic                               md_valid_o
);
   localparam int unsigned AW = swcfg_pkg::ADDR_W;
   localparam int unsigned RW = swcfg_pkg::RATE_W;
   // Settle counter width; SETTLE must fit below two to the CW
   localparam int unsigned CW = 8;

   typedef struct packed {
      swcfg_pkg::cfg_state_t         state;
      logic [CW-1:0]                 cnt;
      // Switch snapshot, taken once after reset
      logic [AW-1:0]                 sw_addr;
      logic [RW-1:0]                 sw_rate;
      // Stored values, written by software
      logic [AW-1:0]                 sto_addr;
      logic [RW-1:0]                 sto_rate;
      logic [AW-1:0]                 addr;
      logic [RW-1:0]                 rate;
      logic [swcfg_pkg::BPS_W-1:0]   bps;
      logic                          addr_sto;
      logic                          rate_sto;
      logic                          md_sel;
      logic                          valid;
      logic                          pready;
      logic [31:0]                   prdata;
      logic                          pslverr;
   } cfg_reg_t;

   cfg_reg_t                          r_q;
   cfg_reg_t                          r_d;
   logic [swcfg_pkg::SW_COUNT-1:0]    sw_sync;
   logic [swcfg_pkg::SW_COUNT-1:0]    sw_on;

   // Elaboration guards refuse settings the logic cannot serve
   if (SETTLE < 1 || SETTLE >= (1 << CW)) begin : g_settle_chk
      $error("SETTLE out of range");
   end
   // Address field below rate field, both inside the bank
   if (swcfg_pkg::ADDR_LSB_SW + AW > swcfg_pkg::RATE_LSB_SW
       || swcfg_pkg::RATE_LSB_SW + RW > swcfg_pkg::SW_COUNT) begin : g_field_chk
      $error("switch fields overlap or overrun the bank");
   end
   // Status fields and bit rate must each fit one bus word
   if (swcfg_pkg::ST_RATE_LSB + RW > swcfg_pkg::ST_ASRC_BIT
       || swcfg_pkg::BPS_W > 32) begin : g_word_chk
      $error("register fields do not fit a word");
   end

   function automatic logic [swcfg_pkg::BPS_W-1:0] rate_to_bps(input logic [RW-1:0] code);
      logic [swcfg_pkg::BPS_W-1:0] v;
      v = swcfg_pkg::BPS_NONE;
      unique case (code)
         swcfg_pkg::RATE_9K6:   v = swcfg_pkg::BPS_9K6;
         swcfg_pkg::RATE_38K4:  v = swcfg_pkg::BPS_38K4;
         swcfg_pkg::RATE_115K2: v = swcfg_pkg::BPS_115K2;
         swcfg_pkg::RATE_NV:    v = swcfg_pkg::BPS_NONE;
      endcase
      return v;
   endfunction

   // Full compare, so no register answers at an alias
   function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction

   level_sync #(
      .WIDTH (swcfg_pkg::SW_COUNT)
   ) u_sw_sync (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .async_i (sw_i),
      .sync_o  (sw_sync)
   );

   // on reads as one
   // An active-low bank would invert here
   for (genvar g = 0; g < swcfg_pkg::SW_COUNT; g++) begin : g_sense
      assign sw_on[g] = sw_sync[g];
   end

   always_comb begin
      logic [31:0] rd;
      logic        access;
      logic        hit;
      rd     = 32'h0000_0000;
      access = psel_i && penable_i;
      hit    = 1'b1;
      r_d    = r_q;

      unique case (r_q.state)
         swcfg_pkg::ST_SETTLE: begin
            // Wait out synchroniser and contact bounce
            if (r_q.cnt == CW'(SETTLE - 1)) begin
               r_d.state = swcfg_pkg::ST_CAPTURE;
            end else begin
               r_d.cnt = r_q.cnt + CW'(1);
            end
         end
         swcfg_pkg::ST_CAPTURE: begin
            // Snapshot taken once, later moves wait for reset
            // address field
            r_d.sw_addr = sw_on[swcfg_pkg::ADDR_LSB_SW +: AW];
            r_d.sw_rate = sw_on[swcfg_pkg::RATE_LSB_SW +: RW];
            r_d.state   = swcfg_pkg::ST_RUN;
         end
         swcfg_pkg::ST_RUN: begin
            r_d.valid = 1'b1;
         end
         // Illegal code restarts the settle count
         default: begin
            r_d.state = swcfg_pkg::ST_SETTLE;
            r_d.cnt   = '0;
         end
      endcase

      // Resolved every cycle so stored writes reach the port
      // independent substitution
      r_d.addr_sto = (r_q.sw_addr == '0);
      r_d.rate_sto = (r_q.sw_rate == swcfg_pkg::RATE_NV);
      r_d.addr     = r_d.addr_sto ? r_q.sto_addr : r_q.sw_addr;
      r_d.rate     = r_d.rate_sto ? r_q.sto_rate : r_q.sw_rate;
      r_d.bps      = rate_to_bps(r_d.rate);
      r_d.md_sel   = ~if_sel_n_i;

      // One wait state, then the answer
      r_d.pready  = access && !r_q.pready;
      r_d.pslverr = 1'b0;
      if (addr_hit(paddr_i, swcfg_pkg::OFS_STORED)) begin
         rd[swcfg_pkg::STO_ADDR_LSB +: AW] = r_q.sto_addr;
         rd[swcfg_pkg::STO_RATE_LSB +: RW] = r_q.sto_rate;
      end else if (addr_hit(paddr_i, swcfg_pkg::OFS_STATUS)) begin
         rd[swcfg_pkg::ST_SWADDR_LSB +: AW] = r_q.sw_addr;
         rd[swcfg_pkg::ST_SWRATE_LSB +: RW] = r_q.sw_rate;
         rd[swcfg_pkg::ST_ADDR_LSB +: AW]   = r_q.addr;
         rd[swcfg_pkg::ST_RATE_LSB +: RW]   = r_q.rate;
         rd[swcfg_pkg::ST_ASRC_BIT]         = r_q.addr_sto;
         rd[swcfg_pkg::ST_RSRC_BIT]         = r_q.rate_sto;
         rd[swcfg_pkg::ST_MDSEL_BIT]        = r_q.md_sel;
         rd[swcfg_pkg::ST_VALID_BIT]        = r_q.valid;
      end else if (addr_hit(paddr_i, swcfg_pkg::OFS_BITRATE)) begin
         rd[swcfg_pkg::BPS_W-1:0] = r_q.bps;
      end else begin
         hit = 1'b0;
      end
      // Word latched in the wait cycle so prdata_o is a flop
      if (access && !r_q.pready) begin
         r_d.prdata  = pwrite_i ? 32'h0000_0000 : rd;
         r_d.pslverr = !hit;
      end
      // Read-only words drop writes without error
      // Write lands on the edge that sees pready
      if (access && r_q.pready && pwrite_i
          && addr_hit(paddr_i, swcfg_pkg::OFS_STORED)) begin
         r_d.sto_addr = pwdata_i[swcfg_pkg::STO_ADDR_LSB +: AW];
         r_d.sto_rate = pwdata_i[swcfg_pkg::STO_RATE_LSB +: RW];
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         r_q          <= '0;
         r_q.state    <= swcfg_pkg::ST_SETTLE;
         // Stored defaults let the port run before software loads them
         r_q.sto_addr <= swcfg_pkg::STO_ADDR_RST;
         r_q.sto_rate <= swcfg_pkg::STO_RATE_RST;
      end else begin
         r_q <= r_d;
      end
   end

   // switch values reach the multidrop outputs and the status register
   assign md_enable_o = r_q.md_sel;
   assign md_addr_o   = r_q.addr;
   assign md_rate_o   = r_q.rate;
   assign md_bps_o    = r_q.bps;
   assign md_valid_o  = r_q.valid;
   assign pready_o    = r_q.pready;
   assign prdata_o    = r_q.prdata;
   assign pslverr_o   = r_q.pslverr;
endmodule // serial_node_switch_config

// [logic/swcfg_pkg.sv]
package swcfg_pkg;
   // Switch bank layout
   localparam int unsigned SW_COUNT      = 8;
   localparam int unsigned ADDR_W        = 6;
   localparam int unsigned RATE_W        = 2;
   localparam int unsigned ADDR_LSB_SW   = 0;
   localparam int unsigned RATE_LSB_SW   = 6;
   localparam int unsigned BPS_W         = 17;

   // Register byte offsets
   localparam logic [11:0] OFS_STORED    = 12'h000;
   localparam logic [11:0] OFS_STATUS    = 12'h004;
   localparam logic [11:0] OFS_BITRATE   = 12'h008;

   // Stored register fields
   localparam int unsigned STO_ADDR_LSB  = 0;
   localparam int unsigned STO_RATE_LSB  = 8;

   // Status register fields
   localparam int unsigned ST_SWADDR_LSB = 0;
   localparam int unsigned ST_SWRATE_LSB = 8;
   localparam int unsigned ST_ADDR_LSB   = 16;
   localparam int unsigned ST_RATE_LSB   = 24;
   localparam int unsigned ST_ASRC_BIT   = 28;
   localparam int unsigned ST_RSRC_BIT   = 29;
   localparam int unsigned ST_MDSEL_BIT  = 30;
   localparam int unsigned ST_VALID_BIT  = 31;

   // Reset values
   localparam logic [ADDR_W-1:0] STO_ADDR_RST = 6'h00;
   localparam logic [RATE_W-1:0] STO_RATE_RST = 2'h1;

   // Bit-rate codes and their rates in bits per second
   localparam logic [RATE_W-1:0] RATE_NV     = 2'h0;
   localparam logic [RATE_W-1:0] RATE_9K6    = 2'h1;
   localparam logic [RATE_W-1:0] RATE_38K4   = 2'h2;
   localparam logic [RATE_W-1:0] RATE_115K2  = 2'h3;
   localparam logic [BPS_W-1:0]  BPS_9K6     = 17'h02580;
   localparam logic [BPS_W-1:0]  BPS_38K4    = 17'h09600;
   localparam logic [BPS_W-1:0]  BPS_115K2   = 17'h1c200;
   localparam logic [BPS_W-1:0]  BPS_NONE    = 17'h00000;

   // Settle time after synchroniser before the snapshot
   localparam int unsigned SETTLE_NS     = 64;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_SETTLE  = 2'h0,
      ST_CAPTURE = 2'h1,
      ST_RUN     = 2'h3
   } cfg_state_t;
endpackage

// [logic/level_sync.sv]
`timescale 1ns/1ps
module level_sync #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   // Levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   if (WIDTH < 1) begin : g_width_chk
      $error("level_sync: WIDTH must be at least 1");
   end

   // First stage feeds only the second stage
   always_comb begin
      s_d        = s_q;
      s_d.meta   = async_i;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_o = s_q.stable;
endmodule // level_sync

// [tb/sel_host_model.sv]
`timescale 1ns/1ps
module sel_host_model (
   // Mode request, high for multidrop
   input  wire logic md_mode_i,
   // Selection pin
   output logic      if_sel_n_o
);
   assign if_sel_n_o = md_mode_i ? 1'b0 : 1'b1;
endmodule // sel_host_model

// [tb/swcfg_sva.sv]
`timescale 1ns/1ps
module swcfg_sva (
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  sw_i,
   input wire logic        if_sel_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic        pslverr_o,
   input wire logic        md_enable_o,
   input wire logic [5:0]  md_addr_o,
   input wire logic [1:0]  md_rate_o,
   input wire logic [16:0] md_bps_o,
   input wire logic        md_valid_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence setup_s; psel_i && !penable_i; endsequence
   sequence access_s; psel_i && penable_i; endsequence
   valid_hold_a: assert property (md_valid_o |=> md_valid_o)
      else $error("valid dropped");
   steady_cfg_a: assert property ((md_valid_o && !psel_i)[*4] |-> $stable(md_addr_o)
      && $stable(md_rate_o)) else $error("config moved");
   bps_map_a: assert property (md_valid_o |-> md_bps_o == (md_rate_o == 2'h3 ? 17'h1c200
      : md_rate_o == 2'h2 ? 17'h09600 : md_rate_o == 2'h1 ? 17'h02580 : 17'h0))
      else $error("bit rate wrong");
   enable_sel_a: assert property (!$past(rst_i) |-> md_enable_o == !$past(if_sel_n_i))
      else $error("enable wrong");
   apb_ready_a: assert property (setup_s ##1 access_s |=> pready_o) else $error("no ready");
   err_data_a: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0)
      else $error("error data");
   sw_addr_a: assert property ($rose(md_valid_o) && sw_i[5:0] != 6'h00
      && $past(sw_i, 8) == sw_i |-> md_addr_o == sw_i[5:0]) else $error("addr wrong");
   sw_rate_a: assert property ($rose(md_valid_o) && sw_i[7:6] != 2'h0
      && $past(sw_i, 8) == sw_i |-> md_rate_o == sw_i[7:6]) else $error("rate wrong");
endmodule // swcfg_sva
bind serial_node_switch_config swcfg_sva i_swcfg_sva (.*);

// [tb/tb_serial_node_switch_config.sv]
`timescale 1ns/1ps
module tb_serial_node_switch_config;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  sw_i = 8'h00;
   logic        md_mode = 1'b1;
   logic        if_sel_n_i;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic        pready_o, pslverr_o, md_enable_o, md_valid_o, er;
   logic [31:0] prdata_o, rd;
   logic [5:0]  md_addr_o;
   logic [1:0]  md_rate_o;
   logic [16:0] md_bps_o;
   logic [7:0]  pat [5] = '{8'h41, 8'ha0, 8'hd5, 8'hc0, 8'h3f};
   int          fail_count = 0;
   int          checks = 0;
   int          cyc = 0;
   sel_host_model i_sel_host_model (.md_mode_i(md_mode), .if_sel_n_o(if_sel_n_i));
   serial_node_switch_config i_serial_node_switch_config (.mclk_i(mclk_i), .rst_i(rst_i),
      .sw_i(sw_i), .if_sel_n_i(if_sel_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
      .prdata_o(prdata_o), .pslverr_o(pslverr_o), .md_enable_o(md_enable_o),
      .md_addr_o(md_addr_o), .md_rate_o(md_rate_o), .md_bps_o(md_bps_o),
      .md_valid_o(md_valid_o));
   initial begin
      forever #4 mclk_i = ~mclk_i;
   end
   task stop_test;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Run is about 200 cycles
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         stop_test();
      end
   end
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      // Wait for the answer; only the bench timeout ends a hang
      do begin
         @(posedge mclk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task boot(input logic [7:0] s);
      rst_i <= 1'b1;
      sw_i <= s;
      repeat (10) @(posedge mclk_i);
      rst_i <= 1'b0;
      while (md_valid_o !== 1'b1) begin
         @(posedge mclk_i);
      end
      @(posedge mclk_i);
   endtask
   function automatic logic [31:0] bps(input logic [1:0] r);
      return r == 2'h3 ? 32'(swcfg_pkg::BPS_115K2) : r == 2'h2 ?
         32'(swcfg_pkg::BPS_38K4) : r == 2'h1 ? 32'(swcfg_pkg::BPS_9K6) : 32'h0;
   endfunction
   task cfg(input logic [5:0] a, input logic [1:0] r);
      repeat (2) @(posedge mclk_i);
      chk("addr", 32'(a), 32'(md_addr_o));
      chk("rate", 32'(r), 32'(md_rate_o));
      chk("bps", bps(r), 32'(md_bps_o));
   endtask
   initial begin
      boot(8'h00);
      cfg(6'h00, 2'h1);
      apb(1'b0, swcfg_pkg::OFS_STORED, 32'h0);
      chk("stored", 32'h100, rd);
      apb(1'b0, swcfg_pkg::OFS_STATUS, 32'h0);
      chk("status", 32'hf1000000, rd);
      apb(1'b1, swcfg_pkg::OFS_STORED, 32'h22a);
      cfg(6'h2a, 2'h2);
      apb(1'b1, swcfg_pkg::OFS_BITRATE, 32'h0);
      apb(1'b0, swcfg_pkg::OFS_BITRATE, 32'h0);
      chk("bitrate", bps(2'h2), rd);
      apb(1'b0, 12'h00c, 32'h0);
      chk("slverr", 32'h1, 32'(er));
      chk("errdata", 32'h0, rd);
      for (int i = 0; i < 5; i++) begin
         md_mode <= i[0];
         boot(pat[i]);
         // Switches move after capture
         sw_i <= ~pat[i];
         apb(1'b1, swcfg_pkg::OFS_STORED, 32'h305);
         cfg(pat[i][5:0] != 6'h00 ? pat[i][5:0] : 6'h05,
            pat[i][7:6] != 2'h0 ? pat[i][7:6] : 2'h3);
         chk("enable", 32'(i[0]), 32'(md_enable_o));
      end
      stop_test();
   end
endmodule // tb_serial_node_switch_config
